/* src/clock_select_and_port_pins.sv */
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module clock_select_and_port_pins #(
	parameter int ADDR_W = 8
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic srst_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [ADDR_W-1:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// oscillators, sampled as levels
	input wire logic main_osc_i,
	input wire logic sub_osc_i,
	// derived clocks
	output logic core_base_clock_o,
	output logic cpu_step_clock_o,
	output logic cpu_step_tick_o,
	// reset pin, open drain
	input wire logic wdt_reset_i,
	input wire logic low_supply_i,
	output logic reset_pin_o,
	output logic reset_pin_oe_n_o,
	// output port bits, open drain
	input wire logic [7:0] out_pin_i,
	output logic [7:0] out_pin_o,
	output logic [7:0] out_pin_oe_n_o,
	output logic ext_int_o,
	// bidirectional ports, open drain
	input wire logic [3:0] first_bidir_port_i,
	output logic [3:0] first_bidir_port_o,
	output logic [3:0] first_bidir_port_oe_n_o,
	output logic [3:0] first_pullup_o,
	input wire logic [3:0] second_bidir_port_i,
	output logic [3:0] second_bidir_port_o,
	output logic [3:0] second_bidir_port_oe_n_o,
	output logic [3:0] second_pullup_o,
	output logic key_wakeup_o,
	// input-only port shared with segments
	input wire logic [3:0] input_only_port_i,
	input wire logic [3:0] seg_data_i,
	output logic [3:0] shared_segment_outputs_o,
	output logic shared_segment_en_o,
	// lcd commons
	output logic [3:0] lcd_common_lines_o
);

	// ***********************************
	// registers
	// ***********************************
	logic [3:0] clock_mode_reg_q;
	logic act_src_q;
	logic act_div_q;
	logic [7:0] out_latch_q;
	logic [3:0] p0_latch_q;
	logic [3:0] p1_latch_q;
	logic [7:0] pullup_ctl_reg_q;
	logic [3:0] cfg_q;
	logic main_prev_q;
	logic sub_prev_q;
	logic base_q;
	logic step_q;
	logic step_tick_q;
	logic ext_int_q;
	logic wake_q;
	logic skip_q;

	// ***********************************
	// bus decode
	// ***********************************
	logic acc_w;
	logic wr_w;
	logic hit_mode_w;
	logic hit_d_w;
	logic hit_p0_w;
	logic hit_p1_w;
	logic hit_pu_w;
	logic hit_cfg_w;
	logic hit_pins_w;
	logic hit_w;
	logic [31:0] rdata_w;

	assign acc_w = psel_i && penable_i;
	assign wr_w = acc_w && pwrite_i;
	assign hit_mode_w = (paddr_i == clock_port_pkg::OFS_MODE);
	assign hit_d_w = (paddr_i == clock_port_pkg::OFS_PORTD);
	assign hit_p0_w = (paddr_i == clock_port_pkg::OFS_PORT0);
	assign hit_p1_w = (paddr_i == clock_port_pkg::OFS_PORT1);
	assign hit_pu_w = (paddr_i == clock_port_pkg::OFS_PULLUP);
	assign hit_cfg_w = (paddr_i == clock_port_pkg::OFS_CFG);
	assign hit_pins_w = (paddr_i == clock_port_pkg::OFS_PINS);
	assign hit_w = hit_mode_w || hit_d_w || hit_p0_w || hit_p1_w || hit_pu_w
		|| hit_cfg_w || hit_pins_w;

	// no wait states; unmapped offsets answer with an error
	assign pready_o = 1'b1;
	assign pslverr_o = acc_w && !hit_w;

	// ***********************************
	// pin sampling
	// ***********************************
	logic [3:0] p0_in_w;
	logic [3:0] p1_in_w;
	logic [3:0] p2_in_w;
	logic seg_sel_w;
	logic subpins_w;

	assign seg_sel_w = cfg_q[clock_port_pkg::CFG_SEG_BIT];
	assign subpins_w = cfg_q[clock_port_pkg::CFG_SUBPINS_BIT];
	// a bit driven low by its own latch reads low, not the far end
	assign p0_in_w = first_bidir_port_i & p0_latch_q;
	assign p1_in_w = second_bidir_port_i & p1_latch_q;
	assign p2_in_w = seg_sel_w ? 4'h0 : input_only_port_i;

	always_comb begin
		rdata_w = 32'h0;
		if (hit_mode_w) begin
			rdata_w[3:0] = clock_mode_reg_q;
			rdata_w[clock_port_pkg::ACT_SRC_BIT] = act_src_q;
			rdata_w[clock_port_pkg::ACT_DIV_BIT] = act_div_q;
		end else if (hit_d_w) begin
			rdata_w[7:0] = out_latch_q;
		end else if (hit_p0_w) begin
			rdata_w[3:0] = p0_latch_q;
		end else if (hit_p1_w) begin
			rdata_w[3:0] = p1_latch_q;
		end else if (hit_pu_w) begin
			rdata_w[7:0] = pullup_ctl_reg_q;
		end else if (hit_cfg_w) begin
			rdata_w[3:0] = cfg_q;
		end else if (hit_pins_w) begin
			rdata_w[15:0] = {2'b00, wake_q, ext_int_q, p2_in_w, p1_in_w, p0_in_w};
		end
	end
	assign prdata_o = acc_w ? rdata_w : 32'h0;

	// ***********************************
	// register writes
	// ***********************************
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			clock_mode_reg_q <= clock_port_pkg::MODE_RST;
			out_latch_q <= clock_port_pkg::PORTD_RST;
			p0_latch_q <= clock_port_pkg::PORT_RST;
			p1_latch_q <= clock_port_pkg::PORT_RST;
			pullup_ctl_reg_q <= clock_port_pkg::PULLUP_RST;
			cfg_q <= clock_port_pkg::CFG_RST;
		end else if (wr_w) begin
			if (hit_mode_w) clock_mode_reg_q <= pwdata_i[3:0];
			if (hit_d_w) out_latch_q <= pwdata_i[7:0];
			if (hit_p0_w) p0_latch_q <= pwdata_i[3:0];
			if (hit_p1_w) p1_latch_q <= pwdata_i[3:0];
			if (hit_pu_w) pullup_ctl_reg_q <= pwdata_i[7:0];
			if (hit_cfg_w) cfg_q <= pwdata_i[3:0];
		end
	end

	// ***********************************
	// clock selection
	// ***********************************
	tick_if #(.W(2)) q4 ();
	tick_if #(.W(2)) q3 ();

	logic main_rise_w;
	logic sub_rise_w;
	logic src_rise_w;
	logic base_tick_w;
	logic want_src_w;
	logic want_div_w;
	logic switch_w;

	assign main_rise_w = main_osc_i && !main_prev_q;
	assign sub_rise_w = sub_osc_i && !sub_prev_q;
	assign src_rise_w = act_src_q ? sub_rise_w : main_rise_w;
	assign q4.in_tick = src_rise_w && !skip_q;
	assign base_tick_w = !skip_q && (act_div_q ? q4.out_tick : src_rise_w);
	assign want_src_w = clock_mode_reg_q[clock_port_pkg::SRC_BIT];
	assign want_div_w = clock_mode_reg_q[clock_port_pkg::DIV_BIT];
	// take a new setting only on a base tick, so no period is cut short
	assign switch_w = base_tick_w && ((want_src_w != act_src_q) || (want_div_w != act_div_q));
	assign q4.clr = switch_w;
	assign q3.in_tick = base_tick_w;
	// step divider keeps its phase across a switch; each base period is whole already
	assign q3.clr = 1'b0;

	tick_divider #(.DIV(clock_port_pkg::BASE_DIV), .W(2)) u_div4 (
		.clock_i(clock_i),
		.srst_i(srst_i),
		.t(q4)
	);

	tick_divider #(.DIV(clock_port_pkg::STEP_DIV), .W(2)) u_div3 (
		.clock_i(clock_i),
		.srst_i(srst_i),
		.t(q3)
	);

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			// a pin already high at release is not taken as a rise
			main_prev_q <= 1'b1;
			sub_prev_q <= 1'b1;
			act_src_q <= 1'b0;
			act_div_q <= 1'b1;
			skip_q <= 1'b0;
		end else begin
			main_prev_q <= main_osc_i;
			sub_prev_q <= sub_osc_i;
			if (switch_w) begin
				act_src_q <= want_src_w;
				act_div_q <= want_div_w;
				// first rise of a new source only marks phase, so no period is cut short
				skip_q <= (want_src_w != act_src_q);
			end else if (src_rise_w) begin
				skip_q <= 1'b0;
			end
		end
	end

	// step clock high for the first base period of each machine cycle
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			base_q <= 1'b0;
			step_q <= 1'b0;
			step_tick_q <= 1'b0;
		end else begin
			if (base_tick_w) base_q <= !base_q;
			step_tick_q <= q3.out_tick;
			if (q3.out_tick) begin
				step_q <= 1'b1;
			end else if (base_tick_w) begin
				step_q <= 1'b0;
			end
		end
	end
	assign core_base_clock_o = base_q;
	assign cpu_step_clock_o = step_q;
	assign cpu_step_tick_o = step_tick_q;

	// ***********************************
	// pins
	// ***********************************
	assign reset_pin_o = 1'b0;
	assign reset_pin_oe_n_o = !(wdt_reset_i || low_supply_i);

	// latch one releases the pin; crystal pins are left to the oscillator
	assign out_pin_o = 8'h00;
	assign out_pin_oe_n_o = {out_latch_q[7:6] | {2{subpins_w}}, out_latch_q[5:0]};
	assign first_bidir_port_o = 4'h0;
	assign first_bidir_port_oe_n_o = p0_latch_q;
	assign second_bidir_port_o = 4'h0;
	assign second_bidir_port_oe_n_o = p1_latch_q;
	assign first_pullup_o = 4'hF;
	assign second_pullup_o = pullup_ctl_reg_q[3:0];

	assign shared_segment_en_o = seg_sel_w;
	assign shared_segment_outputs_o = seg_sel_w ? seg_data_i : 4'h0;

	clock_port_pkg::duty_t duty_w;
	assign duty_w = clock_port_pkg::duty_t'(cfg_q[clock_port_pkg::CFG_DUTY_LSB +: 2]);
	always_comb begin
		case (duty_w)
			clock_port_pkg::DUTY_HALF: lcd_common_lines_o = 4'h3;
			clock_port_pkg::DUTY_THIRD: lcd_common_lines_o = 4'h7;
			clock_port_pkg::DUTY_QUARTER: lcd_common_lines_o = 4'hF;
			default: lcd_common_lines_o = 4'h0;
		endcase
	end

	// second port wakes only through its enabled pins
	logic wake_w;
	assign wake_w = |(~p0_in_w & p0_latch_q)
		|| |(~p1_in_w & p1_latch_q & pullup_ctl_reg_q[7:4]);

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			ext_int_q <= 1'b0;
			wake_q <= 1'b0;
		end else begin
			// the line only carries the far end while its latch is one
			ext_int_q <= out_pin_i[clock_port_pkg::INT_BIT] && out_latch_q[clock_port_pkg::INT_BIT];
			wake_q <= wake_w;
		end
	end
	assign ext_int_o = ext_int_q;
	assign key_wakeup_o = wake_q;

	// ***********************************
	// checks
	// ***********************************
	logic [1:0] base_cnt_q;
	always_ff @(posedge clock_i) begin
		if (srst_i || q3.out_tick) begin
			base_cnt_q <= 2'd0;
		end else if (base_tick_w) begin
			base_cnt_q <= base_cnt_q + 2'd1;
		end
	end

	reset_mode_a: assert property (@(posedge clock_i)
		srst_i |=> (clock_mode_reg_q == 4'h8) && act_div_q && !act_src_q)
		else $error("clock mode not main divided by four after reset");

	src_pick_a: assert property (@(posedge clock_i) disable iff (srst_i)
		base_tick_w && !act_div_q |-> (act_src_q ? sub_rise_w : main_rise_w))
		else $error("undivided base tick not from selected oscillator");

	step_div3_a: assert property (@(posedge clock_i) disable iff (srst_i)
		q3.out_tick |-> base_tick_w ##1 cpu_step_clock_o && cpu_step_tick_o)
		else $error("step clock not raised on third base tick");

	machine_cycle_a: assert property (@(posedge clock_i) disable iff (srst_i)
		q3.out_tick |-> base_cnt_q == 2'd2)
		else $error("machine cycle not three base periods");

	reset_pin_a: assert property (@(posedge clock_i)
		(wdt_reset_i || low_supply_i) |-> !reset_pin_oe_n_o && !reset_pin_o)
		else $error("reset pin not pulled low");

	release_rst_a: assert property (@(posedge clock_i)
		srst_i |=> (first_bidir_port_oe_n_o == 4'hF) && (out_pin_oe_n_o == 8'hFF))
		else $error("port pin driven after reset");

	pullup_write_a: assert property (@(posedge clock_i) disable iff (srst_i)
		wr_w && hit_pu_w |=> second_pullup_o == $past(pwdata_i[3:0]))
		else $error("pull-up control not applied");

	clean_switch_a: assert property (@(posedge clock_i) disable iff (srst_i)
		$changed(act_div_q) || $changed(act_src_q) |-> $past(base_tick_w))
		else $error("clock switched off a base tick");

	sub_pins_a: assert property (@(posedge clock_i) disable iff (srst_i)
		subpins_w |-> out_pin_oe_n_o[7:6] == 2'b11)
		else $error("crystal pins driven");

	com_quarter_a: assert property (@(posedge clock_i) disable iff (srst_i)
		wr_w && hit_cfg_w && pwdata_i[3:2] == 2'b11 |=> lcd_common_lines_o == 4'hF)
		else $error("quarter duty commons wrong");

endmodule

/* src/clock_port_pkg.sv */
package clock_port_pkg;

	// ***********************************
	// register byte offsets
	// ***********************************
	localparam logic [7:0] OFS_MODE = 8'h00;
	localparam logic [7:0] OFS_PORTD = 8'h04;
	localparam logic [7:0] OFS_PORT0 = 8'h08;
	localparam logic [7:0] OFS_PORT1 = 8'h0C;
	localparam logic [7:0] OFS_PULLUP = 8'h10;
	localparam logic [7:0] OFS_CFG = 8'h14;
	localparam logic [7:0] OFS_PINS = 8'h18;

	// ***********************************
	// field positions
	// ***********************************
	localparam int SRC_BIT = 0;
	localparam int DIV_BIT = 3;
	localparam int ACT_SRC_BIT = 4;
	localparam int ACT_DIV_BIT = 5;
	localparam int CFG_SUBPINS_BIT = 0;
	localparam int CFG_SEG_BIT = 1;
	localparam int CFG_DUTY_LSB = 2;
	localparam int INT_BIT = 5;

	// ***********************************
	// reset values
	// ***********************************
	localparam logic [3:0] MODE_RST = 4'h8;
	localparam logic [7:0] PORTD_RST = 8'hFF;
	localparam logic [3:0] PORT_RST = 4'hF;
	localparam logic [7:0] PULLUP_RST = 8'h00;
	localparam logic [3:0] CFG_RST = 4'h0;

	// ***********************************
	// divide ratios and duty codes
	// ***********************************
	localparam int BASE_DIV = 4;
	localparam int STEP_DIV = 3;

	typedef enum logic [1:0] {
		DUTY_OFF = 2'b00,
		DUTY_HALF = 2'b01,
		DUTY_THIRD = 2'b10,
		DUTY_QUARTER = 2'b11
	} duty_t;

endpackage

/* src/tick_if.sv */
`timescale 1ns/1ps
interface tick_if #(parameter int W = 2);
	logic in_tick;
	logic clr;
	logic out_tick;
	logic [W-1:0] phase;
	modport div(input in_tick, input clr, output out_tick, output phase);
	modport user(output in_tick, output clr, input out_tick, input phase);
endinterface

/* src/tick_divider.sv */
`timescale 1ns/1ps
module tick_divider #(
	parameter int DIV = 3,
	parameter int W = 2
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic srst_i,
	// tick stream
	tick_if.div t
);
	logic [W-1:0] phase_q;
	logic [W-1:0] phase_d;
	logic last_w;

	assign last_w = (phase_q == W'(DIV - 1));
	assign phase_d = last_w ? '0 : phase_q + W'(1);
	assign t.out_tick = t.in_tick && last_w;
	assign t.phase = phase_q;

	// restart on clear so a new ratio starts from a whole period
	always_ff @(posedge clock_i) begin
		if (srst_i || t.clr) begin
			phase_q <= '0;
		end else if (t.in_tick) begin
			phase_q <= phase_d;
		end
	end
endmodule

/* testbench/tb.sv */
`timescale 1ns/1ps
module tb;
	// ****
	// signals
	// ****
	logic clock_i, srst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
	logic [7:0] paddr_i, out_pin_i, out_pin_o, out_pin_oe_n_o, out_ext;
	logic [31:0] pwdata_i, prdata_o;
	logic main_osc_i, sub_osc_i, core_base_clock_o, cpu_step_clock_o, cpu_step_tick_o;
	logic wdt_reset_i, low_supply_i, reset_pin_o, reset_pin_oe_n_o, ext_int_o;
	logic key_wakeup_o, shared_segment_en_o;
	logic [3:0] first_bidir_port_i, first_bidir_port_o, first_bidir_port_oe_n_o, first_pullup_o;
	logic [3:0] second_bidir_port_i, second_bidir_port_o, second_bidir_port_oe_n_o;
	logic [3:0] second_pullup_o, input_only_port_i, seg_data_i, shared_segment_outputs_o;
	logic [3:0] lcd_common_lines_o, p0_ext, p1_ext;
	logic [1:0] oc = 2'h0;
	int sc = 0;
	int cyc = 0;
	int num_errors = 0;
	int n_checks = 0;
	logic [7:0] adr[5] = '{clock_port_pkg::OFS_PORTD, clock_port_pkg::OFS_PORT0,
		clock_port_pkg::OFS_PORT1, clock_port_pkg::OFS_PULLUP, clock_port_pkg::OFS_CFG};
	logic [3:0] com_tab[4] = '{4'h0, 4'h3, 4'h7, 4'hF};

	// open drain: a pin reads low while the device pulls it
	assign out_pin_i = out_ext & out_pin_oe_n_o;
	assign first_bidir_port_i = p0_ext & first_bidir_port_oe_n_o;
	assign second_bidir_port_i = p1_ext & second_bidir_port_oe_n_o;

	clock_select_and_port_pins dut (
		.clock_i, .srst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
		.prdata_o, .pready_o, .pslverr_o, .main_osc_i, .sub_osc_i, .core_base_clock_o,
		.cpu_step_clock_o, .cpu_step_tick_o, .wdt_reset_i, .low_supply_i, .reset_pin_o,
		.reset_pin_oe_n_o, .out_pin_i, .out_pin_o, .out_pin_oe_n_o, .ext_int_o,
		.first_bidir_port_i, .first_bidir_port_o, .first_bidir_port_oe_n_o, .first_pullup_o,
		.second_bidir_port_i, .second_bidir_port_o, .second_bidir_port_oe_n_o,
		.second_pullup_o, .key_wakeup_o, .input_only_port_i, .seg_data_i,
		.shared_segment_outputs_o, .shared_segment_en_o, .lcd_common_lines_o
	);

	// ****
	// clock, oscillators, watchdog on the run
	// ****
	initial begin
		clock_i = 1'b0;
		forever #10 clock_i = ~clock_i;
	end

	// main rises every 4 clocks, sub every 6: both slower than clock/2
	always @(posedge clock_i) begin
		oc <= oc + 2'h1;
		sc <= (sc == 5) ? 0 : sc + 1;
		main_osc_i <= oc[1];
		sub_osc_i <= (sc < 3);
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			num_errors++;
			test_done();
		end
	end

	// ****
	// tasks
	// ****
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			$display("mismatch %s expected %h seen %h", name, exp, got);
			num_errors++;
		end
	endtask

	// entered just after a rising edge; leaves one idle edge so psel never toggles twice
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic er);
		psel_i <= 1'b1;
		pwrite_i <= wr;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clock_i);
		penable_i <= 1'b1;
		@(posedge clock_i);
		while (pready_o !== 1'b1) begin
			@(posedge clock_i);
		end
		rd = prdata_o;
		er = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		@(posedge clock_i);
	endtask

	// the first intervals may straddle a mode switch, so only the last one counts
	// t counts base clock changes and h step clock high cycles within the same interval
	task automatic period(output int p, output int t, output int h);
		logic b;
		repeat (4) begin
			p = 0;
			t = 0;
			h = 0;
			b = core_base_clock_o;
			do begin
				@(posedge clock_i);
				p++;
				if (core_base_clock_o !== b) t++;
				b = core_base_clock_o;
				if (cpu_step_clock_o === 1'b1) h++;
			end while (cpu_step_tick_o !== 1'b1 && p < 300);
		end
	endtask

	function automatic int exp_period(logic src, logic div);
		return (src ? 6 : 4) * (div ? clock_port_pkg::BASE_DIV : 1) * clock_port_pkg::STEP_DIV;
	endfunction

	// ****
	// tests
	// ****
	initial begin
		logic [31:0] r, q, rd, vals[5];
		logic er, kw;
		int p, t, h;
		srst_i = 1'b1;
		{psel_i, penable_i, pwrite_i, wdt_reset_i, low_supply_i} = '0;
		{paddr_i, pwdata_i, out_ext, p0_ext, p1_ext, input_only_port_i, seg_data_i} = '0;
		void'($urandom(32'hD0ABED44));
		repeat (5) @(posedge clock_i);
		srst_i <= 1'b0;
		@(posedge clock_i);
		chk("oe_n after reset", 32'hFFFF, {out_pin_oe_n_o, first_bidir_port_oe_n_o,
			second_bidir_port_oe_n_o});
		vals = '{32'hFF, 32'hF, 32'hF, 32'h0, 32'h0};
		for (int i = 0; i < 5; i++) begin
			apb(1'b0, adr[i], 32'h0, rd, er);
			chk("reset value", vals[i], rd);
		end
		apb(1'b0, clock_port_pkg::OFS_MODE, 32'h0, rd, er);
		chk("mode after reset", 32'h28, rd);
		period(p, t, h);
		chk("step period", 32'(exp_period(1'b0, 1'b1)), 32'(p));
		chk("base toggles", 32'(clock_port_pkg::STEP_DIV), 32'(t));
		chk("step high", 32'(exp_period(1'b0, 1'b1) / clock_port_pkg::STEP_DIV), 32'(h));
		$display("test reset done");

		for (int m = 0; m < 4; m++) begin
			apb(1'b1, clock_port_pkg::OFS_MODE, {28'h0, m[1], 2'b00, m[0]}, rd, er);
			period(p, t, h);
			chk("step period", 32'(exp_period(m[0], m[1])), 32'(p));
			chk("base toggles", 32'(clock_port_pkg::STEP_DIV), 32'(t));
			chk("step high", 32'(exp_period(m[0], m[1]) / clock_port_pkg::STEP_DIV), 32'(h));
			apb(1'b0, clock_port_pkg::OFS_MODE, 32'h0, rd, er);
			chk("mode readback", {26'h0, m[1], m[0], m[1], 2'b00, m[0]}, rd);
		end
		$display("test clock select done");

		apb(1'b1, 8'h1C, 32'hFFFFFFFF, rd, er);
		chk("unmapped write error", 32'h1, {31'h0, er});
		apb(1'b0, 8'h1C, 32'h0, rd, er);
		chk("unmapped read", 32'h0, rd);
		chk("unmapped read error", 32'h1, {31'h0, er});
		$display("test unmapped done");

		for (int k = 0; k < 24; k++) begin
			r = (k == 0) ? 32'hFFFFFFFF : (k == 1) ? 32'h0 : $urandom;
			r[23:16] = {{4{r[20]}}, {4{r[16]}}};
			q = $urandom;
			{wdt_reset_i, low_supply_i, out_ext, p0_ext, p1_ext, input_only_port_i,
				seg_data_i} <= q[25:0];
			vals = '{{24'h0, r[7:0]}, {28'h0, r[11:8]}, {28'h0, r[15:12]}, {24'h0, r[23:16]},
				{28'h0, r[27:24]}};
			for (int i = 0; i < 5; i++) begin
				apb(1'b1, adr[i], vals[i] | {q[31:28], 28'h0}, rd, er);
			end
			for (int i = 0; i < 5; i++) begin
				apb(1'b0, adr[i], 32'h0, rd, er);
				chk("readback", vals[i], rd);
				chk("readback error", 32'h0, {31'h0, er});
			end
			@(posedge clock_i);
			chk("reset pin oe_n", {31'h0, ~(wdt_reset_i | low_supply_i)},
				{31'h0, reset_pin_oe_n_o});
			chk("pin drive", 32'h0, {out_pin_o, first_bidir_port_o, second_bidir_port_o,
				reset_pin_o});
			chk("out oe_n", {24'h0, r[7:0] | (r[24] ? 8'hC0 : 8'h00)}, out_pin_oe_n_o);
			chk("port oe_n", r[15:8], {second_bidir_port_oe_n_o, first_bidir_port_oe_n_o});
			chk("pullups", {4'hF, r[19:16]}, {first_pullup_o, second_pullup_o});
			chk("segments", {r[25], r[25] ? seg_data_i : 4'h0},
				{shared_segment_en_o, shared_segment_outputs_o});
			chk("commons", com_tab[r[27:26]], lcd_common_lines_o);
			chk("ext int", out_ext[5] & r[5], ext_int_o);
			kw = |(~p0_ext & r[11:8]) | |(~p1_ext & r[15:12] & r[23:20]);
			chk("key wakeup", kw, key_wakeup_o);
			apb(1'b0, clock_port_pkg::OFS_PINS, 32'h0, rd, er);
			chk("pins", {18'h0, kw, out_ext[5] & r[5], r[25] ? 4'h0 : input_only_port_i,
				p1_ext & r[15:12], p0_ext & r[11:8]}, rd);
		end
		$display("test ports done");
		test_done();
	end
endmodule
